//--- rtl/ieg_irq_gate.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module ieg_irq_gate
	import ieg_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_ce,
	// Register port
	input  wire ieg_pkg::ieg_bus_t      i_bus,
	output logic [ieg_pkg::DATA_W-1:0]  o_rdata,
	// Event sources
	input  wire ieg_pkg::ieg_evt_t      i_evt,
	// Core handshake
	input  wire logic                   i_core_ack,
	output logic                        o_core_req,
	output logic [15:0]                 o_vector,
	output logic                        o_vector_load,
	// Status interrupt
	output logic                        o_irq
);
	import ieg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic logic hit(input ieg_bus_t b, input logic [3:0] off);
		return b.addr == off;
	endfunction

	wire wr_ctrl   = i_bus.wr & hit(i_bus, OFF_CTRL);
	wire wr_pie_a  = i_bus.wr & hit(i_bus, OFF_PIE_A);
	wire wr_pie_b  = i_bus.wr & hit(i_bus, OFF_PIE_B);
	wire wr_pfl_a  = i_bus.wr & hit(i_bus, OFF_PFLAG_A);
	wire wr_pfl_b  = i_bus.wr & hit(i_bus, OFF_PFLAG_B);
	wire wr_pin    = i_bus.wr & hit(i_bus, OFF_PIN_FLG);
	wire wr_opt    = i_bus.wr & hit(i_bus, OFF_OPTION);
	wire wr_stat   = i_bus.wr & hit(i_bus, OFF_STATUS);
	wire wr_mask   = i_bus.wr & hit(i_bus, OFF_MASK);

	////////////////////////////////////////////////////////////////////////////
	// Enable registers
	logic [7:0] ctrl_en_r;
	logic [7:0] ctrl_en_nxt;
	logic [7:0] pie_a_r;
	logic [7:0] pie_b_r;
	logic       edge_sel_r;
	logic [EV_N-1:0] mask_r;
	logic       accept;

	// Accept clears the global enable; hardware clear outranks a write
	always_comb begin
		ctrl_en_nxt = wr_ctrl ? (i_bus.wdata & 8'hf8) : ctrl_en_r; // RULE19
		if (accept) begin
			ctrl_en_nxt[BIT_GIE] = 1'b0; // RULE15
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_en_r  <= RESET_VAL; // RULE13 RULE17
			pie_a_r    <= RESET_VAL;
			pie_b_r    <= RESET_VAL;
			edge_sel_r <= 1'b0;
			mask_r     <= '0;
		end else if (i_ce) begin
			ctrl_en_r <= ctrl_en_nxt;
			if (wr_pie_a) begin
				pie_a_r <= i_bus.wdata & PIE_A_MASK; // RULE10
			end
			if (wr_pie_b) begin
				pie_b_r <= i_bus.wdata & PIE_B_MASK; // RULE11 RULE12
			end
			if (wr_opt) begin
				edge_sel_r <= i_bus.wdata[0];
			end
			if (wr_mask) begin
				mask_r <= i_bus.wdata[EV_N-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags: external edge, core flags, pin flags, peripheral flags
	logic ext_edge;
	ieg_edge_det u_edge (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_pin     (i_evt.ext_pin),
		.i_rising  (edge_sel_r),
		.o_edge    (ext_edge)
	);

	// Core flags: bit1 tick0, bit0 external; cleared by writing zero
	logic [1:0] core_flag;
	wire  [1:0] core_clr = {2{wr_ctrl}} & ~{i_bus.wdata[BIT_T0F], i_bus.wdata[BIT_EXF]};
	ieg_flag_bank #(.N(2)) u_core (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_set     ({i_evt.tick0_ovf, ext_edge}), // RULE6 RULE7
		.i_clr     (core_clr),
		.o_flag    (core_flag)
	);
	wire tick0_overflow_flag = core_flag[1];
	wire ext_pin_irq_flag    = core_flag[0];

	// Per-pin change flags, cleared by writing zero
	logic [7:0] per_pin_change_flags;
	ieg_flag_bank #(.N(8)) u_pins (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_set     (i_evt.pin_change),
		.i_clr     ({8{wr_pin}} & ~i_bus.wdata),
		.o_flag    (per_pin_change_flags)
	);
	// Summary follows the pin flags and ignores writes
	wire pin_change_summary_flag = |(per_pin_change_flags & PIN_MASK); // RULE8 RULE9

	// Peripheral flags, laid out like the enables
	logic [PERIPH_N-1:0] pflag;
	wire  [PERIPH_N-1:0] pflag_clr = {{8{wr_pfl_b}} & ~i_bus.wdata,
	                                  {8{wr_pfl_a}} & ~i_bus.wdata};
	ieg_flag_bank #(.N(PERIPH_N)) u_per (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_set     (i_evt.periph & {PIE_B_MASK, PIE_A_MASK}), // RULE4
		.i_clr     (pflag_clr),
		.o_flag    (pflag)
	);

	////////////////////////////////////////////////////////////////////////////
	// Request combine
	wire global_irq_enable  = ctrl_en_r[BIT_GIE];
	wire periph_group_enable = ctrl_en_r[BIT_PERIPH_GROUP_ENABLE];
	wire core_any = (ctrl_en_r[BIT_T0E] & tick0_overflow_flag)      // RULE6 RULE14
	              | (ctrl_en_r[BIT_EXE] & ext_pin_irq_flag)         // RULE7
	              | (ctrl_en_r[BIT_PCE] & pin_change_summary_flag); // RULE8
	wire per_any  = periph_group_enable & |(pflag & {pie_b_r, pie_a_r});           // RULE2 RULE3 RULE14
	wire req_comb = global_irq_enable & (core_any | per_any);                     // RULE1 RULE18
	assign accept = req_comb & i_core_ack;

	////////////////////////////////////////////////////////////////////////////
	// Own status: request seen, request accepted; set beats clear
	logic [EV_N-1:0] stat_r;
	wire  [EV_N-1:0] stat_set = {accept, req_comb};
	wire  [EV_N-1:0] stat_clr = {EV_N{wr_stat}} & i_bus.wdata[EV_N-1:0];

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stat_r <= '0;
		end else if (i_ce) begin
			stat_r <= stat_set | (stat_r & ~stat_clr); // RULE19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux, reserved bits read zero
	wire [7:0] ctrl_rd = {ctrl_en_r[7:3], tick0_overflow_flag, ext_pin_irq_flag,
	                      pin_change_summary_flag};
	wire [7:0] rd_mux =
		hit(i_bus, OFF_CTRL)    ? ctrl_rd :
		hit(i_bus, OFF_PIE_A)   ? pie_a_r :
		hit(i_bus, OFF_PIE_B)   ? (pie_b_r & PIE_B_MASK) : // RULE12
		hit(i_bus, OFF_PFLAG_A) ? pflag[7:0] :
		hit(i_bus, OFF_PFLAG_B) ? pflag[15:8] :
		hit(i_bus, OFF_PIN_FLG) ? per_pin_change_flags :
		hit(i_bus, OFF_OPTION)  ? {7'h00, edge_sel_r} :
		hit(i_bus, OFF_STATUS)  ? {6'h00, stat_r} :
		hit(i_bus, OFF_MASK)    ? {6'h00, mask_r} : 8'h00;

	// Registered outputs
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata       <= 8'h00;
			o_core_req    <= 1'b0;
			o_vector      <= 16'h0000;
			o_vector_load <= 1'b0;
			o_irq         <= 1'b0;
		end else if (i_ce) begin
			o_rdata       <= i_bus.rd ? rd_mux : 8'h00;
			o_core_req    <= req_comb & ~accept;
			o_vector      <= VECTOR_ADDR;
			o_vector_load <= accept; // RULE15
			o_irq         <= |((stat_set | (stat_r & ~stat_clr)) & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_GIE_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE1
		(i_ce && !global_irq_enable) |=> !o_core_req) else $error("request without global enable");
	AST_PERIPH_GROUP_ENABLE_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE2
		(i_ce && !periph_group_enable && !core_any) |=> !o_core_req) else $error("peripheral leak");
	AST_ACCEPT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE15
		(i_ce && accept) |=> (!ctrl_en_r[BIT_GIE] && o_vector_load)) else $error("accept");
	AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE4
		(i_ce && i_evt.tick0_ovf) |=> tick0_overflow_flag) else $error("tick0 flag lost");
	AST_SUMMARY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE9
		pin_change_summary_flag == (per_pin_change_flags != 8'h00)) else $error("summary");
	AST_PIE_B_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE12
		(pie_b_r & ~PIE_B_MASK) == 8'h00) else $error("reserved set");
	AST_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE16
		(i_ce && edge_sel_r && $rose(i_evt.ext_pin) && $past(i_ce)) |=> ext_pin_irq_flag)
		else $error("rising edge missed");
	AST_REQ: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RULE18
		(i_ce && req_comb && !accept) |=> o_core_req) else $error("request dropped");
endmodule

//--- pkg/ieg_pkg.sv
// Contract
// RULE1 - Global enable gates every core request
// RULE2 - Group enable gates all peripheral sources
// RULE3 - Peripheral needs own, group, global enables
// RULE4 - Flags set regardless of any enable
// RULE5 - Software clears flags before enabling sources
// RULE6 - Tick0 overflow flag bit2, enable bit5
// RULE7 - External pin flag bit1, enable bit4
// RULE8 - Pin-change summary flag bit0, enable bit3
// RULE9 - Summary flag read-only, clears with pin flags
// RULE10 - Peripheral enable A full bit map
// RULE11 - Peripheral enable B bits 6,3,2,1
// RULE12 - Unimplemented enable B bits read zero
// RULE13 - All implemented bits reset to zero
// RULE14 - Enable passes flag, never alters it
// RULE15 - Accepted request clears global enable, vectors
// RULE16 - Edge select: one rising, zero falling
// RULE17 - Reset leaves every interrupt disabled
// RULE18 - Request is gated OR of pairs
// RULE19 - Writes next edge; hardware set beats clear
package ieg_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int PERIPH_N = 16;
	// Register offsets
	localparam logic [3:0] OFF_CTRL    = 4'h0;
	localparam logic [3:0] OFF_PIE_A   = 4'h1;
	localparam logic [3:0] OFF_PIE_B   = 4'h2;
	localparam logic [3:0] OFF_PFLAG_A = 4'h3;
	localparam logic [3:0] OFF_PFLAG_B = 4'h4;
	localparam logic [3:0] OFF_PIN_FLG = 4'h5;
	localparam logic [3:0] OFF_OPTION  = 4'h6;
	localparam logic [3:0] OFF_STATUS  = 4'h7;
	localparam logic [3:0] OFF_MASK    = 4'h8;
	// Control register fields
	localparam int BIT_GIE  = 7;
	localparam int BIT_PERIPH_GROUP_ENABLE = 6;
	localparam int BIT_T0E  = 5;
	localparam int BIT_EXE  = 4;
	localparam int BIT_PCE  = 3;
	localparam int BIT_T0F  = 2;
	localparam int BIT_EXF  = 1;
	localparam int BIT_PCF  = 0;
	// Writable masks and reset values
	localparam logic [7:0] CTRL_WMASK  = 8'hfe;
	localparam logic [7:0] PIE_A_MASK  = 8'hff;
	localparam logic [7:0] PIE_B_MASK  = 8'h4e;
	localparam logic [7:0] RESET_VAL   = 8'h00;
	localparam logic [7:0] PIN_MASK    = 8'hff;
	localparam logic [15:0] VECTOR_ADDR = 16'h0004;
	// Own status events
	localparam int EV_REQ = 0;
	localparam int EV_ACC = 1;
	localparam int EV_N   = 2;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ieg_bus_t;

	typedef struct packed {
		logic       tick0_ovf;
		logic       ext_pin;
		logic [7:0] pin_change;
		logic [15:0] periph;
	} ieg_evt_t;
endpackage

//--- rtl/ieg_edge_det.sv
`timescale 1ns/10ps
module ieg_edge_det (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	input  wire logic i_ce,
	// Pin and select
	input  wire logic i_pin,
	input  wire logic i_rising,
	output logic      o_edge
);
	logic prev_r;

	// Previous level for edge compare
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_r <= 1'b0;
		end else if (i_ce) begin
			prev_r <= i_pin;
		end
	end

	assign o_edge = i_ce & (i_rising ? (i_pin & ~prev_r) : (~i_pin & prev_r)); // RULE16
endmodule

//--- rtl/ieg_flag_bank.sv
`timescale 1ns/10ps
module ieg_flag_bank #(
	parameter int N = 8
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset_n,
	input  wire logic         i_ce,
	// Set and clear
	input  wire logic [N-1:0] i_set,
	input  wire logic [N-1:0] i_clr,
	output logic      [N-1:0] o_flag
);
	logic [N-1:0] flag_r;
	logic [N-1:0] flag_nxt;

	// Set wins over a clear in the same cycle
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			assign flag_nxt[g] = i_set[g] | (flag_r[g] & ~i_clr[g]); // RULE19
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flag_r <= '0; // RULE13
		end else if (i_ce) begin
			flag_r <= flag_nxt; // RULE4
		end
	end

	assign o_flag = flag_r;
endmodule

//--- dv/ieg_core_model.sv
`timescale 1ns/10ps
module ieg_core_model (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_reset_n,
	// Request and pacing
	input  wire logic       i_req,
	input  wire logic [3:0] i_delay,
	output logic            o_ack
);
	logic [3:0] wait_r;

	// Sequencer takes a standing request after i_delay cycles; one-cycle ack avoids a double take
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_r <= 4'h0;
			o_ack  <= 1'b0;
		end else if (o_ack || !i_req) begin
			wait_r <= 4'h0;
			o_ack  <= 1'b0;
		end else if (wait_r == i_delay) begin
			o_ack  <= 1'b1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule

//--- dv/irq_enable_flag_gating_tb_top.sv
`timescale 1ns/10ps
module irq_enable_flag_gating_tb_top;
	import ieg_pkg::*;
	logic clk, rst_n, ack, req, vld, irq, pend, pin_lvl, ce;
	ieg_bus_t bus;
	ieg_evt_t evt;
	logic [7:0] rdata, r;
	logic [15:0] vec;
	logic [3:0] dly;
	logic [7:0] rq[$];
	logic [15:0] vq[$];
	int err_total, samples_checked, cyc;
	int seed = 32'h3806053b;

	ieg_irq_gate dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_bus(bus),
		.o_rdata(rdata), .i_evt(evt), .i_core_ack(ack), .o_core_req(req),
		.o_vector(vec), .o_vector_load(vld), .o_irq(irq));
	ieg_core_model core (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_delay(dly),
		.o_ack(ack));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop;
		if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Bus cycles: strobe one cycle, then an idle edge so no signal is set twice per step
	task automatic bop(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk) bus <= '0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bop(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rq.push_back(e);
		bop(1'b0, a, 8'h00);
	endtask
	task automatic ev(input logic t0, input logic [7:0] pc, input logic [15:0] pr);
		@(posedge clk) evt <= '{tick0_ovf: t0, ext_pin: pin_lvl, pin_change: pc, periph: pr};
		@(posedge clk) evt <= '{tick0_ovf: 1'b0, ext_pin: pin_lvl, pin_change: 8'h0, periph: 16'h0};
	endtask
	task automatic pin(input logic v);
		pin_lvl = v;
		@(posedge clk) evt.ext_pin <= v;
		repeat (2) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	// Watcher: read data one cycle after the strobe, vector on each load pulse
	always @(negedge clk) begin
		if (pend) chk({8'h00, rdata}, {8'h00, rq.pop_front()}, "read data");
		pend = bus.rd;
		if (vld) begin
			if (vq.size() == 0) chk(16'h1, 16'h0, "unexpected accept");
			else chk(vec, vq.pop_front(), "vector");
		end
	end

	// Hang guard well above the sequence length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0; bus = '0; evt = '0; dly = 4'h3; pin_lvl = 1'b0; pend = 1'b0; ce = 1'b1;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFF_CTRL, 8'h00);
		rd(OFF_PIE_A, 8'h00);
		rd(OFF_PIE_B, 8'h00);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = 8'($random(seed));
			wr(OFF_PIE_A, r);
			rd(OFF_PIE_A, r);
			wr(OFF_PIE_B, r);
			rd(OFF_PIE_B, r & 8'h4e);
		end
		wr(OFF_CTRL, 8'hff);
		rd(OFF_CTRL, 8'hf8);
		wr(OFF_CTRL, 8'h00);
		ev(1'b1, 8'h00, 16'h0000);
		rd(OFF_CTRL, 8'h04);
		wr(OFF_CTRL, 8'h00);
		wr(OFF_OPTION, 8'h01);
		pin(1'b1);
		rd(OFF_CTRL, 8'h02);
		wr(OFF_CTRL, 8'h00);
		wr(OFF_OPTION, 8'h00);
		pin(1'b0);
		rd(OFF_CTRL, 8'h02);
		wr(OFF_CTRL, 8'h00);
		pin(1'b1);
		rd(OFF_CTRL, 8'h00);
		ev(1'b0, 8'h08, 16'h0000);
		rd(OFF_CTRL, 8'h01);
		wr(OFF_CTRL, 8'h00);
		rd(OFF_CTRL, 8'h01);
		wr(OFF_PIN_FLG, 8'h00);
		rd(OFF_CTRL, 8'h00);
		// Slow accept of a core source, seen in status and on the level output
		wr(OFF_MASK, 8'h03);
		vq.push_back(VECTOR_ADDR);
		wr(OFF_CTRL, 8'ha0);
		ev(1'b1, 8'h00, 16'h0000);
		repeat (10) @(posedge clk);
		rd(OFF_CTRL, 8'h24);
		chk({15'h0, irq}, 16'h1, "irq");
		chk({15'h0, req}, 16'h0, "request after accept");
		rd(OFF_STATUS, 8'h03);
		wr(OFF_STATUS, 8'h03);
		repeat (2) @(posedge clk);
		chk({15'h0, irq}, 16'h0, "irq clear");
		// Peripheral source held off by the group enable, then taken promptly
		wr(OFF_PIE_A, 8'h01);
		wr(OFF_PIE_B, 8'h00);
		dly <= 4'h0;
		ev(1'b0, 8'h00, 16'h0001);
		wr(OFF_CTRL, 8'h80);
		repeat (6) @(posedge clk);
		rd(OFF_PFLAG_A, 8'h01);
		chk({15'h0, req}, 16'h0, "group enable leak");
		vq.push_back(VECTOR_ADDR);
		wr(OFF_CTRL, 8'hc0);
		repeat (6) @(posedge clk);
		rd(OFF_CTRL, 8'h40);
		repeat (2) @(posedge clk);
		chk(vq.size(), 16'h0, "missing accept");
		// Clock enable low freezes state: an overflow pulse then is not recorded
		@(posedge clk) ce <= 1'b0;
		ev(1'b1, 8'h00, 16'h0000);
		@(posedge clk) ce <= 1'b1;
		rd(OFF_CTRL, 8'h40);
		repeat (2) @(posedge clk);
		report_and_stop();
	end
endmodule
